//--- src/olfs_params.svh
// register map, parameter defaults, legal ranges and arithmetic scales of the set-point path
`ifndef OLFS_PARAMS_SVH
`define OLFS_PARAMS_SVH
`define OLFS_NPROG 10
`define OLFS_PROG_MAX 16'h0009
// global registers (byte addresses)
`define OLFS_A_PROG 12'h000
`define OLFS_A_MAP 12'h004
`define OLFS_A_FLOW 12'h008
`define OLFS_A_GAIN 12'h00c
// per-program block: base + program * stride + field offset
`define OLFS_A_PBASE 12'h100
`define OLFS_PSTRIDE 12'h040
`define OLFS_F_CP 12'h000
`define OLFS_F_DZ 12'h004
`define OLFS_F_CURVE 12'h008
`define OLFS_F_QMAX 12'h00c
`define OLFS_F_SENSE 12'h010
`define OLFS_F_G0 12'h014
`define OLFS_F_SPAN 12'h02c
`define OLFS_F_LAST 12'h02c
// map register bits
`define OLFS_MAP_POS 0
`define OLFS_MAP_SPD 1
// defaults
`define OLFS_D_CP 16'h0000
`define OLFS_D_DZ 16'h0032
`define OLFS_D_CURVE 16'h0000
`define OLFS_D_QMAX 16'h03e8
`define OLFS_D_SENSE 16'h0001
`define OLFS_D_SPAN 16'h01f4
`define OLFS_D_G0 105
`define OLFS_D_GSTEP 15
// legal ranges
`define OLFS_DZ_MAX 250
`define OLFS_CURVE_LIM 10
`define OLFS_QMAX_MAX 1000
`define OLFS_G_MIN 20
`define OLFS_G_MAX 1200
`define OLFS_SPAN_MIN 1
`define OLFS_SPAN_MAX 1000
`define OLFS_SENSE_MAX 3
// arithmetic scales
`define OLFS_FULL 1000
`define OLFS_GAIN_UNIT 100
`define OLFS_SAT 32767
`define OLFS_CURVE_DIV 10
`endif

//--- src/olfs_pkg.sv
// shared types of the set-point path
package olfs_pkg;
    typedef enum logic [1:0] {
        OLFS_IDLE = 2'b00,
        OLFS_GAIN = 2'b01,
        OLFS_SHAPE = 2'b10
    } olfs_state_t;
    typedef enum logic [1:0] {
        OLFS_SENSE_NONE = 2'b00,
        OLFS_SENSE_FIXED = 2'b01,
        OLFS_SENSE_POS = 2'b10,
        OLFS_SENSE_SPEED = 2'b11
    } olfs_sense_t;
endpackage : olfs_pkg

//--- src/olfs_gain.sv
// steering gain selection: fixed, position table or speed table
`timescale 1ns/1ps
`include "olfs_params.svh"
module olfs_gain (
    // mode and operating point
    input wire logic [1:0] sense,
    input wire logic [10:0] pos_mag,
    input wire logic [11:0] speed_mag,
    input wire logic [9:0] span,
    // gain breakpoints
    input wire logic [10:0] gain_point_zero,
    input wire logic [10:0] gain_point_one,
    input wire logic [10:0] gain_point_two,
    input wire logic [10:0] gain_point_three,
    input wire logic [10:0] gain_point_four,
    input wire logic [10:0] gain_point_five,
    // selected gain
    output logic [10:0] gain
);
    // linear interpolation between two gains, zero-width span takes the far point
    function automatic int interp(input int ga, input int gb, input int x, input int xa,
                                  input int xb);
        if (xb <= xa)
            return gb;
        return ga + ((gb - ga) * (x - xa)) / (xb - xa);
    endfunction : interp

    int g [6];
    int bp [6];
    int res;
    int p;
    // breakpoints at 0, 1/16, 1/8, 1/4, 1/2 and all of the span
    always_comb
    begin
        g[0] = int'(gain_point_zero);
        g[1] = int'(gain_point_one);
        g[2] = int'(gain_point_two);
        g[3] = int'(gain_point_three);
        g[4] = int'(gain_point_four);
        g[5] = int'(gain_point_five);
        bp[0] = 0;
        for (int i = 1; i < 6; i++)
            bp[i] = int'(span) >> (5 - i);
        p = (int'(pos_mag) > `OLFS_FULL) ? `OLFS_FULL : int'(pos_mag);
        res = g[0];
        case (sense)
            olfs_pkg::OLFS_SENSE_POS:
                res = interp(g[0], g[1], p, 0, `OLFS_FULL);
            olfs_pkg::OLFS_SENSE_SPEED:
            begin
                res = g[5];
                for (int i = 4; i >= 0; i--)
                    if (int'(speed_mag) < bp[i + 1])
                        res = interp(g[i], g[i + 1], int'(speed_mag), bp[i], bp[i + 1]);
                if (speed_mag == 12'h000)
                    res = g[0];
            end
            default:
                res = g[0];
        endcase
        gain = res[10:0];
    end
endmodule : olfs_gain

//--- src/olfs_shaper.sv
// dead zone, curve shaping, gain and flow limit
`timescale 1ns/1ps
`include "olfs_params.svh"
module olfs_shaper (
    // steering sample and settings
    input wire logic signed [10:0] steer,
    input wire logic [7:0] dead_zone,
    input wire logic signed [4:0] curve_shape,
    input wire logic [9:0] max_flow_limit,
    input wire logic [10:0] gain,
    // requested flow
    output logic signed [10:0] flow
);
    int mag;
    int m;
    int r;
    int shaped;
    int prod;
    int lim;
    // magnitude path, sign restored at the end
    always_comb
    begin
        mag = (steer < 0) ? -int'(steer) : int'(steer);
        if (mag > `OLFS_FULL)
            mag = `OLFS_FULL;
        r = `OLFS_FULL - int'(dead_zone);
        m = (mag > int'(dead_zone)) ? mag - int'(dead_zone) : 0;
        // bow the line: positive setting progressive, negative regressive
        shaped = m - (int'(curve_shape) * m * (r - m)) / (`OLFS_CURVE_DIV * r);
        if (shaped < 0)
            shaped = 0;
        prod = (shaped * int'(gain)) / `OLFS_GAIN_UNIT;
        if (prod > `OLFS_SAT)
            prod = `OLFS_SAT;
        lim = (prod > int'(max_flow_limit)) ? int'(max_flow_limit) : prod;
        if (steer < 0)
            lim = -lim;
        flow = lim[10:0];
    end
endmodule : olfs_shaper

//--- src/olfs_top.sv
// open-loop flow set-point path with apb parameter store
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "olfs_params.svh"
module olfs_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sampled inputs
    input wire logic sample_valid,
    input wire logic signed [10:0] steer_in,
    input wire logic signed [10:0] actuator_position,
    input wire logic signed [11:0] road_speed_signal,
    // flow request
    output logic signed [10:0] port_flow,
    output logic flow_valid
);
    // clamp a written value into its legal range
    function automatic logic [15:0] fit(input int v, input int lo, input int hi);
        int t;
        t = (v < lo) ? lo : ((v > hi) ? hi : v);
        return t[15:0];
    endfunction : fit

    // absolute value of a signed sample
    function automatic logic [11:0] absv(input logic signed [11:0] v);
        return (v < 0) ? 12'(-v) : 12'(v);
    endfunction : absv

    // per-program parameter store
    logic [15:0] cp_mem [`OLFS_NPROG];
    logic [15:0] dz_mem [`OLFS_NPROG];
    logic [15:0] curve_mem [`OLFS_NPROG];
    logic [15:0] qmax_mem [`OLFS_NPROG];
    logic [15:0] sense_mem [`OLFS_NPROG];
    logic [15:0] g_mem [`OLFS_NPROG][6];
    logic [15:0] span_mem [`OLFS_NPROG];
    logic [15:0] next_cp_mem [`OLFS_NPROG];
    logic [15:0] next_dz_mem [`OLFS_NPROG];
    logic [15:0] next_curve_mem [`OLFS_NPROG];
    logic [15:0] next_qmax_mem [`OLFS_NPROG];
    logic [15:0] next_sense_mem [`OLFS_NPROG];
    logic [15:0] next_g_mem [`OLFS_NPROG][6];
    logic [15:0] next_span_mem [`OLFS_NPROG];
    logic [3:0] prog;
    logic [3:0] next_prog;
    logic [1:0] map;
    logic [1:0] next_map;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [10:0] gain_reg;
    int gain_defaults [6];

    // apb decode: answer registered in the setup cycle, write lands at the access edge
    always_comb
    begin
        int rel;
        int pi;
        int fo;
        int wv;
        rel = 0;
        pi = 0;
        fo = 0;
        wv = int'(pwdata[15:0]);
        next_prog = prog;
        next_map = map;
        next_cp_mem = cp_mem;
        next_dz_mem = dz_mem;
        next_curve_mem = curve_mem;
        next_qmax_mem = qmax_mem;
        next_sense_mem = sense_mem;
        next_g_mem = g_mem;
        next_span_mem = span_mem;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        next_pready = psel && !penable;
        if (paddr >= `OLFS_A_PBASE)
        begin
            rel = int'(paddr - `OLFS_A_PBASE);
            pi = rel / int'(`OLFS_PSTRIDE);
            fo = rel % int'(`OLFS_PSTRIDE);
        end
        if (paddr == `OLFS_A_PROG)
            next_prdata = {28'h000_0000, prog};
        else if (paddr == `OLFS_A_MAP)
            next_prdata = {30'h0000_0000, map};
        else if (paddr == `OLFS_A_FLOW)
            next_prdata = {{21{port_flow[10]}}, port_flow};
        else if (paddr == `OLFS_A_GAIN)
            next_prdata = {21'h00_0000, gain_reg};
        else if (paddr >= `OLFS_A_PBASE && pi < `OLFS_NPROG && fo <= int'(`OLFS_F_LAST)
                 && paddr[1:0] == 2'b00)
        begin
            if (fo == int'(`OLFS_F_CP))
                next_prdata = {16'h0000, cp_mem[pi]};
            else if (fo == int'(`OLFS_F_DZ))
                next_prdata = {16'h0000, dz_mem[pi]};
            else if (fo == int'(`OLFS_F_CURVE))
                next_prdata = {{16{curve_mem[pi][15]}}, curve_mem[pi]};
            else if (fo == int'(`OLFS_F_QMAX))
                next_prdata = {16'h0000, qmax_mem[pi]};
            else if (fo == int'(`OLFS_F_SENSE))
                next_prdata = {16'h0000, sense_mem[pi]};
            else if (fo == int'(`OLFS_F_SPAN))
                next_prdata = {16'h0000, span_mem[pi]};
            else
                next_prdata = {16'h0000, g_mem[pi][(fo - int'(`OLFS_F_G0)) / 4]};
        end
        else
            next_pslverr = psel && !penable; // unmapped address
        // write at the access edge, clamped to the legal range
        if (psel && penable && pready && pwrite && !pslverr)
        begin
            if (paddr == `OLFS_A_PROG)
                next_prog = 4'(fit(wv, 0, int'(`OLFS_PROG_MAX)));
            else if (paddr == `OLFS_A_MAP)
                next_map = pwdata[1:0];
            else if (paddr >= `OLFS_A_PBASE)
            begin
                if (fo == int'(`OLFS_F_CP))
                    next_cp_mem[pi] = pwdata[15:0];
                else if (fo == int'(`OLFS_F_DZ))
                    next_dz_mem[pi] = fit(wv, 0, `OLFS_DZ_MAX);
                else if (fo == int'(`OLFS_F_CURVE))
                    next_curve_mem[pi] = fit(int'($signed(pwdata[15:0])), -`OLFS_CURVE_LIM,
                                             `OLFS_CURVE_LIM);
                else if (fo == int'(`OLFS_F_QMAX))
                    next_qmax_mem[pi] = fit(wv, 0, `OLFS_QMAX_MAX);
                else if (fo == int'(`OLFS_F_SENSE))
                    next_sense_mem[pi] = fit(wv, 0, `OLFS_SENSE_MAX);
                else if (fo == int'(`OLFS_F_SPAN))
                    next_span_mem[pi] = fit(wv, `OLFS_SPAN_MIN, `OLFS_SPAN_MAX);
                else if (fo >= int'(`OLFS_F_G0))
                    next_g_mem[pi][(fo - int'(`OLFS_F_G0)) / 4] =
                        fit(wv, `OLFS_G_MIN, `OLFS_G_MAX);
            end
        end
    end

    // default gains, falling by fifteen per speed point
    always_comb
    begin
        gain_defaults[0] = `OLFS_D_G0;
        for (int i = 1; i < 6; i++)
            gain_defaults[i] = gain_defaults[i - 1] - `OLFS_D_GSTEP;
    end

    // register store and apb answer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prog <= 4'h0;
            map <= 2'b00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            for (int i = 0; i < `OLFS_NPROG; i++)
            begin
                cp_mem[i] <= `OLFS_D_CP;
                dz_mem[i] <= `OLFS_D_DZ;
                curve_mem[i] <= `OLFS_D_CURVE;
                qmax_mem[i] <= `OLFS_D_QMAX;
                sense_mem[i] <= `OLFS_D_SENSE;
                span_mem[i] <= `OLFS_D_SPAN;
                for (int j = 0; j < 6; j++)
                    g_mem[i][j] <= gain_defaults[j][15:0];
            end
        end
        else
        begin
            prog <= next_prog;
            map <= next_map;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            cp_mem <= next_cp_mem;
            dz_mem <= next_dz_mem;
            curve_mem <= next_curve_mem;
            qmax_mem <= next_qmax_mem;
            sense_mem <= next_sense_mem;
            g_mem <= next_g_mem;
            span_mem <= next_span_mem;
        end
    end

    // computation sequencer: capture, gain, shape
    olfs_pkg::olfs_state_t state;
    olfs_pkg::olfs_state_t next_state;
    logic [3:0] lprog;
    logic [3:0] next_lprog;
    logic signed [10:0] lsteer;
    logic signed [10:0] next_lsteer;
    logic [10:0] lpos;
    logic [10:0] next_lpos;
    logic [11:0] lspeed;
    logic [11:0] next_lspeed;
    logic [10:0] next_gain_reg;
    logic signed [10:0] next_port_flow;
    logic next_flow_valid;
    logic [10:0] gain_sel;
    logic signed [10:0] shaped_flow;

    olfs_gain u_gain (
        .sense(sense_mem[lprog][1:0]),
        .pos_mag(lpos),
        .speed_mag(lspeed),
        .span(span_mem[lprog][9:0]),
        .gain_point_zero(g_mem[lprog][0][10:0]),
        .gain_point_one(g_mem[lprog][1][10:0]),
        .gain_point_two(g_mem[lprog][2][10:0]),
        .gain_point_three(g_mem[lprog][3][10:0]),
        .gain_point_four(g_mem[lprog][4][10:0]),
        .gain_point_five(g_mem[lprog][5][10:0]),
        .gain(gain_sel)
    );

    olfs_shaper u_shaper (
        .steer(lsteer),
        .dead_zone(dz_mem[lprog][7:0]),
        .curve_shape(curve_mem[lprog][4:0]),
        .max_flow_limit(qmax_mem[lprog][9:0]),
        .gain(gain_reg),
        .flow(shaped_flow)
    );

    // next state of the sequencer
    always_comb
    begin
        next_state = state;
        next_lprog = lprog;
        next_lsteer = lsteer;
        next_lpos = lpos;
        next_lspeed = lspeed;
        next_gain_reg = gain_reg;
        next_port_flow = port_flow;
        next_flow_valid = 1'b0;
        case (state)
            olfs_pkg::OLFS_IDLE:
                if (sample_valid)
                begin
                    next_lprog = prog;
                    next_lsteer = steer_in;
                    next_lpos = map[`OLFS_MAP_POS] ? 11'(absv(12'(actuator_position)))
                        : 11'h000;
                    next_lspeed = map[`OLFS_MAP_SPD] ? absv(road_speed_signal)
                        : 12'h000;
                    next_state = olfs_pkg::OLFS_GAIN;
                end
            olfs_pkg::OLFS_GAIN:
            begin
                next_gain_reg = gain_sel;
                next_state = olfs_pkg::OLFS_SHAPE;
            end
            olfs_pkg::OLFS_SHAPE:
            begin
                next_port_flow = (cp_mem[lprog] == `OLFS_D_CP) ? shaped_flow
                    : 11'h000;
                next_flow_valid = 1'b1;
                next_state = olfs_pkg::OLFS_IDLE;
            end
            default:
                next_state = olfs_pkg::OLFS_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= olfs_pkg::OLFS_IDLE;
            lprog <= 4'h0;
            lsteer <= 11'h000;
            lpos <= 11'h000;
            lspeed <= 12'h000;
            gain_reg <= 11'h000;
            port_flow <= 11'h000;
            flow_valid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            lprog <= next_lprog;
            lsteer <= next_lsteer;
            lpos <= next_lpos;
            lspeed <= next_lspeed;
            gain_reg <= next_gain_reg;
            port_flow <= next_port_flow;
            flow_valid <= next_flow_valid;
        end
    end

    // checks on the computed flow and gain, the apb answer and the program index
    property p_latency;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_IDLE && sample_valid) |-> ##3 flow_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("flow not ready three cycles on");
    property p_cp_off;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_SHAPE && cp_mem[lprog] != `OLFS_D_CP) |=> port_flow == 0;
    endproperty
    a_cp_off: assert property (p_cp_off) else $error("flow while not open loop");
    property p_limit;
        @(posedge clk) disable iff (rst)
        flow_valid |-> (port_flow < 0 ? -int'(port_flow) : int'(port_flow))
            <= int'(qmax_mem[lprog]);
    endproperty
    a_limit: assert property (p_limit) else $error("flow beyond limit");
    property p_dead;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_SHAPE && int'(absv(12'(lsteer))) <= int'(dz_mem[lprog]))
            |=> port_flow == 0;
    endproperty
    a_dead: assert property (p_dead) else $error("flow inside dead zone");
    property p_sign;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_SHAPE && lsteer < 0) |=> port_flow <= 0;
    endproperty
    a_sign: assert property (p_sign) else $error("flow sign wrong");
    property p_fixed;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_GAIN && sense_mem[lprog] == 16'h0001)
            |=> gain_reg == g_mem[lprog][0][10:0];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed gain not used");
    property p_nopos;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_IDLE && sample_valid && !map[`OLFS_MAP_POS]) |=> lpos == 0;
    endproperty
    a_nopos: assert property (p_nopos) else $error("unmapped position not zero");
    property p_nospd;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_GAIN && lspeed == 0 && sense_mem[lprog] == 16'h0003)
            |=> gain_reg == g_mem[lprog][0][10:0];
    endproperty
    a_nospd: assert property (p_nospd) else $error("standstill gain not used");
    property p_top;
        @(posedge clk) disable iff (rst)
        (state == olfs_pkg::OLFS_GAIN && sense_mem[lprog] == 16'h0003
            && lspeed >= span_mem[lprog][11:0]) |=> gain_reg == g_mem[lprog][5][10:0];
    endproperty
    a_top: assert property (p_top) else $error("last gain not held");
    property p_apb;
        @(posedge clk) disable iff (rst)
        (psel && !penable) |=> pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer late");
    property p_prog;
        @(posedge clk) disable iff (rst)
        1'b1 |-> prog <= `OLFS_PROG_MAX;
    endproperty
    a_prog: assert property (p_prog) else $error("program index out of range");
    c_flow: cover property (@(posedge clk) disable iff (rst) flow_valid && port_flow > 0);
    c_neg: cover property (@(posedge clk) disable iff (rst) flow_valid && port_flow < 0);
    c_speed: cover property (@(posedge clk) disable iff (rst)
        state == olfs_pkg::OLFS_GAIN && sense_mem[lprog] == 16'h0003 && lspeed != 0);
    c_err: cover property (@(posedge clk) disable iff (rst) pslverr);
endmodule : olfs_top

//--- verif/olfs_steer_dev.sv
// spring-return steering input device model
`timescale 1ns/1ps
module olfs_steer_dev (
    // clock
    input wire logic clk,
    // sample strobe and deflection
    output logic sample_valid,
    output logic signed [10:0] steer_in
);
    initial
    begin
        sample_valid = 1'b0;
        steer_in = 11'sh000;
    end
    // one sample: deflection qualified for a single edge, then no longer held
    task deflect(input logic signed [10:0] v);
        @(posedge clk);
        sample_valid <= 1'b1;
        steer_in <= v;
        @(posedge clk);
        sample_valid <= 1'b0;
        steer_in <= ~v; // stale value is not kept
    endtask : deflect
endmodule : olfs_steer_dev

//--- verif/open_loop_flow_setpoint_tb.sv
// self-checking bench of the open-loop flow set-point path
`timescale 1ns/1ps
`include "olfs_params.svh"
module open_loop_flow_setpoint_tb;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, flow_valid, sample_valid, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic signed [10:0] steer_in, port_flow, actuator_position = 11'sh000;
    logic signed [11:0] road_speed_signal = 12'sh000;
    logic signed [10:0] exp_q[$];
    int failures = 0, checks_done = 0;
    localparam logic [11:0] PB = `OLFS_A_PBASE;
    // clock
    always #12.5 clk = ~clk;
    olfs_top u_olfs_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .steer_in(steer_in),
        .actuator_position(actuator_position), .road_speed_signal(road_speed_signal),
        .port_flow(port_flow), .flow_valid(flow_valid));
    olfs_steer_dev u_olfs_steer_dev (.clk(clk), .sample_valid(sample_valid),
        .steer_in(steer_in));
    task check(input logic [31:0] got, input logic [31:0] want, input string what);
        checks_done++;
        if (got !== want)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, got, want);
        end
    endtask : check
    // apb transfer: setup, access held until pready sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one sample with its expected flow noted for the monitor
    task flow(input logic signed [10:0] s, input logic signed [10:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        u_olfs_steer_dev.deflect(s);
        while (exp_q.size() != 0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20)
            failures++;
    endtask : flow
    // monitor: each result is compared with the oldest note
    always @(posedge clk)
        if (flow_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h1, 32'h0, "unexpected flow");
            else
                check(32'(port_flow), 32'(exp_q.pop_front()), "flow");
        end
    task tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        tally_and_finish;
    end
    // main sequence
    initial
    begin
        logic [11:0] fa[6] = '{`OLFS_F_CP, `OLFS_F_DZ, `OLFS_F_QMAX, `OLFS_F_G0,
            `OLFS_F_G0 + 12'h004, `OLFS_F_SPAN};
        logic [31:0] fv[6] = '{32'h0, 32'h32, 32'h3e8, 32'h69, 32'h5a, 32'h1f4};
        void'($urandom(32'hbda0));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, PB + fa[i], 32'h0);
            check(rd, fv[i], "default");
        end
        apb(1'b0, PB + 12'h280, 32'h0);
        check(32'(err), 32'h1, "program ten refused");
        $display("test defaults done");
        flow(11'sd500, 11'sd472);
        flow(-11'sd500, -11'sd472);
        flow(11'sd1000, 11'sd997);
        for (int i = 0; i < 4; i++)
            flow(11'($urandom_range(100)) - 11'sd50, 11'sd0);
        apb(1'b1, PB + `OLFS_F_DZ, 32'h0);
        flow(11'sd500, 11'sd525);
        apb(1'b1, PB + `OLFS_F_DZ, 32'h32);
        apb(1'b1, PB + `OLFS_F_QMAX, 32'h12c);
        flow(11'sd1000, 11'sd300);
        apb(1'b1, PB + `OLFS_F_CURVE, 32'ha);
        flow(11'sd500, 11'sd224);
        apb(1'b1, PB + `OLFS_F_CURVE, 32'h0);
        apb(1'b1, PB + `OLFS_F_QMAX, 32'h3e8);
        apb(1'b1, PB + `OLFS_F_CP, 32'h1);
        flow(11'sd500, 11'sd0);
        apb(1'b1, PB + `OLFS_F_CP, 32'h0);
        apb(1'b1, PB + `OLFS_PSTRIDE + `OLFS_F_QMAX, 32'hc8);
        apb(1'b1, `OLFS_A_PROG, 32'h1);
        flow(11'sd1000, 11'sd200);
        apb(1'b1, `OLFS_A_PROG, 32'hc);
        apb(1'b0, `OLFS_A_PROG, 32'h0);
        check(rd, 32'h9, "program clamp");
        apb(1'b1, `OLFS_A_PROG, 32'h0);
        $display("test fixed gain done");
        apb(1'b1, PB + `OLFS_F_SENSE, 32'h2);
        actuator_position <= 11'sd1000;
        flow(11'sd500, 11'sd472);
        apb(1'b1, `OLFS_A_MAP, 32'h1);
        flow(11'sd500, 11'sd405);
        actuator_position <= -11'sd1000;
        flow(11'sd500, 11'sd405);
        actuator_position <= 11'sd0;
        flow(11'sd500, 11'sd472);
        $display("test position gain done");
        apb(1'b1, PB + `OLFS_F_SENSE, 32'h3); // default gains fall with speed
        road_speed_signal <= 12'sd600;
        flow(11'sd500, 11'sd472);
        apb(1'b1, `OLFS_A_MAP, 32'h2);
        flow(11'sd500, 11'sd135);
        road_speed_signal <= -12'sd250;
        flow(11'sd500, 11'sd202);
        road_speed_signal <= 12'sd31;
        flow(11'sd500, 11'sd405);
        road_speed_signal <= 12'sd0;
        flow(11'sd500, 11'sd472);
        $display("test speed gain done");
        apb(1'b1, PB + `OLFS_F_SENSE, 32'h1);
        apb(1'b1, PB + `OLFS_F_G0, 32'h514);
        apb(1'b0, PB + `OLFS_F_G0, 32'h0);
        check(rd, 32'h4b0, "gain clamp");
        flow(11'sd1000, 11'sd1000);
        $display("test saturation done");
        tally_and_finish;
    end
endmodule : open_loop_flow_setpoint_tb
